// *** bench/rtp_channel_tb.sv ***
// Self-checking testbench for the reload timer PWM channel.
// Assumes the block alone, APB driven from here, pin watched directly.
`timescale 1ns/1ps
`default_nettype none

module rtp_channel_tb
    import rtp_pkg::*;
;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite; // Bus inputs
    logic [11:0] paddr;                               // Byte address
    logic [31:0] pwdata, prdata;                      // Data buses
    logic        pready, pslverr, pin;                // Outputs
    logic [31:0] rd;                                  // Last read data
    logic        er;                                  // Last error flag
    int          miscompares, n_tests;                // Tallies

    rtp_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .channel_output_pin(pin));

    // Free-running 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Verdict and end of run
    task automatic test_done();
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One value compared against its expectation
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; holds the request until pready at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            miscompares++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read a register and compare data and error flag
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("rdata", e, rd);
        chk("pslverr", 32'h0, {31'h0, er});
    endtask

    // Program the channel, settle, count high cycles of the pin
    task automatic pwm(input logic [11:0] rl, dt, input logic [1:0] ct,
                       input int n, input int e);
        int hi;
        hi = 0;
        apb(1'b1, RTP_OFF_RELOAD, {20'h0, rl});
        apb(1'b1, RTP_OFF_DUTY3, {20'h0, dt});
        apb(1'b1, RTP_OFF_CTRL, {30'h0, ct});
        repeat (40) @(posedge pclk);
        repeat (n) begin
            @(posedge pclk);
            if (pin === 1'b1) hi++;
        end
        chk("pin_high_cycles", 32'(e), 32'(hi));
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        miscompares = 0;
        n_tests = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(RTP_OFF_RELOAD, 32'h0);
        rdchk(RTP_OFF_DUTY3, 32'h0);
        rdchk(RTP_OFF_CTRL, 32'h0);
        apb(1'b1, RTP_OFF_RELOAD, 32'h0000_0fff);
        rdchk(RTP_OFF_RELOAD, 32'h0000_0fff);
        apb(1'b1, RTP_OFF_DUTY3, 32'hffff_ffff);
        rdchk(RTP_OFF_DUTY3, 32'h0000_0fff);
        // Unmapped place: write dropped, read zero with error
        apb(1'b1, 12'h010, 32'h0000_0123);
        chk("unmapped_wr_err", 32'h1, {31'h0, er});
        rdchk(RTP_OFF_RELOAD, 32'h0000_0fff);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_rdata", 32'h0, rd);
        chk("unmapped_err", 32'h1, {31'h0, er});
        // Counter starts at zero; let it reach the short period
        apb(1'b1, RTP_OFF_RELOAD, 32'h0000_0ff0);
        repeat (4100) @(posedge pclk);
        pwm(12'hff0, 12'hff8, 2'h1, 32, 18);
        pwm(12'hff0, 12'hff8, 2'h3, 32, 14);
        rdchk(RTP_OFF_CTRL, 32'h0000_0003);
        pwm(12'hff0, 12'hff8, 2'h0, 32, 0);
        pwm(12'hfe0, 12'hfe7, 2'h1, 64, 16);
        pwm(12'hff8, 12'hff0, 2'h1, 32, 0);
        pwm(12'hff8, 12'hff0, 2'h3, 32, 32);
        // Counter pinned at top: status shows counter and pin
        pwm(12'hfff, 12'hfff, 2'h1, 8, 8);
        rdchk(RTP_OFF_STATUS, 32'h0001_0fff);
        pwm(12'hfff, 12'hffe, 2'h1, 8, 0);
        rdchk(RTP_OFF_STATUS, 32'h0000_0fff);
        pwm(12'hfff, 12'hffe, 2'h3, 8, 8);
        rdchk(RTP_OFF_STATUS, 32'h0001_0fff);
        test_done();
    end

endmodule // rtp_channel_tb

`default_nettype wire

// *** verilog/rtp_channel.sv ***
// Reload timer with its third PWM channel, behind an APB slave.
// Assumes an APB master on pclk; the counter clock is pclk itself.
// Notes on behaviour
// - 12-bit reload value sets PWM period
// - First polarity: high at or below duty
// - Second polarity: low at or below duty
// - Channel owns 12-bit duty compare register
// - Channel three selectable, own polarity, duty
`timescale 1ns/1ps
`default_nettype none

module rtp_channel
    import rtp_pkg::*;
(
    input  wire logic        pclk,              // Bus and counter clock
    input  wire logic        presetn,           // Async reset, active low
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB access phase
    input  wire logic        pwrite,            // APB direction
    input  wire logic [11:0] paddr,             // APB byte address
    input  wire logic [31:0] pwdata,            // APB write data
    output logic      [31:0] prdata,            // APB read data
    output logic             pready,            // APB ready
    output logic             pslverr,           // APB error
    output logic             channel_output_pin // PWM pin
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [11:0] reload_r;      // Reload value register
    logic [11:0] reload_nxt;    // Reload value after this edge
    logic [11:0] duty_r;        // Channel 3 duty compare
    logic [11:0] duty_nxt;      // Duty compare after this edge
    logic        sel_r;         // Channel 3 enabled
    logic        sel_nxt;       // Channel select after this edge
    rtp_pol_t    pol_r;         // Channel 3 polarity
    rtp_pol_t    pol_nxt;       // Polarity after this edge
    logic [11:0] cnt_r;         // Free running counter
    logic [11:0] cnt_nxt;       // Next counter value
    logic        pin_nxt;       // Next pin level
    logic        setup;         // Setup phase seen
    logic        access;        // Access phase with ready
    logic        wr_en;         // Write takes effect
    logic        rd_en;         // Read data is captured
    logic        known;         // Address is mapped
    logic [31:0] rd_word;       // Word chosen for a read

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Address hits one of the four words
    function automatic logic rtp_mapped(input logic [11:0] a);
        return a == RTP_OFF_RELOAD || a == RTP_OFF_DUTY3 ||
               a == RTP_OFF_CTRL   || a == RTP_OFF_STATUS;
    endfunction

    // Level of the pin for one counter value; idle low when deselected
    function automatic logic rtp_level(input logic        sel,
                                       input rtp_pol_t    pol,
                                       input logic [11:0] cnt,
                                       input logic [11:0] duty);
        if (!sel) begin
            return 1'b0;
        end else if (pol == polarity_high_until_compare) begin
            return cnt <= duty;
        end else begin
            return cnt > duty;
        end
    endfunction

    // Write strobe aimed at one register word
    function automatic logic rtp_wr_hit(input logic        en,
                                        input logic [11:0] a,
                                        input logic [11:0] off);
        return en && a == off;
    endfunction

    // Bus phases; an access is the cycle that completes a transfer
    assign setup  = psel && !penable;               // First bus cycle
    assign access = psel && penable && pready;      // Completing cycle
    assign known  = rtp_mapped(paddr);              // Decoded address
    assign wr_en  = access && pwrite && known;      // Register update
    assign rd_en  = setup && !pwrite;               // Read capture

    // ----------------------------------------------------------------
    // APB handshake: one wait-free access after each setup
    // ----------------------------------------------------------------
    // Ready rises for exactly the access cycle following setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !known;  // Unmapped answers with error
        end
    end

    // Word selected by the read address; unmapped and unused bits zero
    always_comb begin
        rd_word = 32'h0000_0000;                      // Default all zero
        unique case (paddr)
            RTP_OFF_RELOAD: begin
                rd_word[11:0] = reload_r;
            end
            RTP_OFF_DUTY3: begin
                rd_word[11:0] = duty_r;
            end
            RTP_OFF_CTRL: begin
                rd_word[RTP_CTRL_SEL] = sel_r;
                rd_word[RTP_CTRL_POL] = pol_r;
            end
            RTP_OFF_STATUS: begin
                rd_word[11:0]         = cnt_r;        // Counter value
                rd_word[RTP_STAT_PIN] = channel_output_pin; // Pin level
            end
            default: begin
                rd_word = 32'h0000_0000;              // Unmapped reads zero
            end
        endcase
    end

    // Read data captured in the setup cycle, held until the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rd_word;                        // Read answer
        end else if (setup) begin
            prdata <= 32'h0000_0000;                  // Write reads zero
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Reload value, full 12-bit range; holds unless written
    always_comb begin
        if (rtp_wr_hit(wr_en, paddr, RTP_OFF_RELOAD)) begin
            reload_nxt = pwdata[11:0];
        end else begin
            reload_nxt = reload_r;                    // Hold
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_r <= RTP_RELOAD_RST;
        end else begin
            reload_r <= reload_nxt;
        end
    end

    // Channel duty compare, full 12-bit range; holds unless written
    always_comb begin
        if (rtp_wr_hit(wr_en, paddr, RTP_OFF_DUTY3)) begin
            duty_nxt = pwdata[11:0];
        end else begin
            duty_nxt = duty_r;                        // Hold
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_r <= RTP_DUTY_RST;
        end else begin
            duty_r <= duty_nxt;
        end
    end

    // Channel select and polarity; upper bits of the word are dropped
    always_comb begin
        if (rtp_wr_hit(wr_en, paddr, RTP_OFF_CTRL)) begin
            sel_nxt = pwdata[RTP_CTRL_SEL];
            pol_nxt = rtp_pol_t'(pwdata[RTP_CTRL_POL]);
        end else begin
            sel_nxt = sel_r;                          // Hold
            pol_nxt = pol_r;                          // Hold
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= 1'b0;
            pol_r <= polarity_high_until_compare;
        end else begin
            sel_r <= sel_nxt;
            pol_r <= pol_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // Count up to the top, then restart at the reload value
    // A reload written mid-period takes hold at the next wrap
    always_comb begin
        if (cnt_r == RTP_CNT_MAX) begin
            cnt_nxt = reload_r;
        end else begin
            cnt_nxt = cnt_r + 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= RTP_RELOAD_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Compare and pin
    // ----------------------------------------------------------------
    // Level from compare and polarity; idle low when deselected.
    // Every input is taken at its value after this edge, so the pin
    // moves in the same cycle as a duty, polarity or select write
    // and never shows one cycle of a stale compare.
    always_comb begin
        pin_nxt = rtp_level(sel_nxt, pol_nxt,
                            cnt_nxt, duty_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_output_pin <= 1'b0;
        end else begin
            channel_output_pin <= pin_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    pin_pol_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        sel_r && pol_r == polarity_high_until_compare
        |-> channel_output_pin == (cnt_r <= duty_r))
        else $error("pin wrong for first polarity");

    pin_pol_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        sel_r && pol_r == polarity_low_until_compare
        |-> channel_output_pin == (cnt_r > duty_r))
        else $error("pin wrong for second polarity");

    cnt_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_r == RTP_CNT_MAX |=> cnt_r == $past(reload_r))
        else $error("counter did not reload");

    cnt_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_r != RTP_CNT_MAX |=> cnt_r == $past(cnt_r) + 12'h001)
        else $error("counter did not step");

    reload_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == RTP_OFF_RELOAD
        |=> reload_r == $past(pwdata[11:0]))
        else $error("reload write lost");

    duty_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == RTP_OFF_DUTY3
        |=> duty_r == $past(pwdata[11:0]))
        else $error("duty write lost");

    ctrl_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == RTP_OFF_CTRL
        |=> sel_r == $past(pwdata[RTP_CTRL_SEL])
            && pol_r == $past(pwdata[RTP_CTRL_POL]))
        else $error("control write lost");

    pin_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_r |-> !channel_output_pin)
        else $error("deselected pin not low");

    rd_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && paddr == RTP_OFF_RELOAD
        |-> prdata[11:0] == $past(reload_r))
        else $error("reload read wrong");

    rd_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && paddr == RTP_OFF_DUTY3
        |-> prdata[11:0] == $past(duty_r))
        else $error("duty read wrong");

    rd_status_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && paddr == RTP_OFF_STATUS
        |-> prdata[11:0] == $past(cnt_r)
            && prdata[RTP_STAT_PIN] == $past(channel_output_pin))
        else $error("status read wrong");

    err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
        access |-> pslverr == !known)
        else $error("error flag wrong");

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("ready not one cycle");

endmodule : rtp_channel

`default_nettype wire

// *** verilog/rtp_pkg.sv ***
// Constants for the reload timer PWM channel block.
// Assumes a 32-bit APB slave port on a single 50 MHz clock.
package rtp_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] RTP_OFF_RELOAD  = 12'h000;  // Reload value
    localparam logic [11:0] RTP_OFF_DUTY3   = 12'h004;  // Channel 3 duty
    localparam logic [11:0] RTP_OFF_CTRL    = 12'h008;  // Channel control
    localparam logic [11:0] RTP_OFF_STATUS  = 12'h00c;  // Counter, pin

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int          RTP_CTRL_SEL    = 0;        // Channel select
    localparam int          RTP_CTRL_POL    = 1;        // Polarity bit
    localparam int          RTP_STAT_PIN    = 16;       // Pin level bit
    localparam logic [11:0] RTP_CNT_MAX     = 12'hfff;  // Counter top
    localparam logic [11:0] RTP_RELOAD_RST  = 12'h000;  // Reload at reset
    localparam logic [11:0] RTP_DUTY_RST    = 12'h000;  // Duty at reset

    // Polarity settings
    typedef enum logic {
        polarity_high_until_compare = 1'b0,
        polarity_low_until_compare  = 1'b1
    } rtp_pol_t;

endpackage : rtp_pkg
